// file: design/hrm_pkg.sv
// shared constants and types of the hub receive monitor
package hrm_pkg;

    // -------------------------------------------------------------
    // sizes
    // -------------------------------------------------------------
    localparam int PORTS  = 8;
    localparam int CNT_W  = 20;
    localparam int MON_W  = 17;
    localparam int DIV_W  = 6;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int ST_W   = 3;

    // -------------------------------------------------------------
    // counts in mid clock periods (defaults of top parameters)
    // -------------------------------------------------------------
    localparam int LAMP_TICKS_DEF = 500000;
    localparam int MON_TICKS_DEF  = 131072;

    // mid clock divide ratios per rate select code
    localparam logic [DIV_W-1:0] DIV_RATE3 = 6'h04;
    localparam logic [DIV_W-1:0] DIV_RATE2 = 6'h08;
    localparam logic [DIV_W-1:0] DIV_RATE1 = 6'h10;
    localparam logic [DIV_W-1:0] DIV_RATE0 = 6'h20;

    // -------------------------------------------------------------
    // register map
    // -------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] REG_MASK   = 4'h1;
    localparam logic [ADDR_W-1:0] REG_PORTS  = 4'h2;
    localparam logic [ADDR_W-1:0] REG_LIVE   = 4'h3;
    localparam int ST_RX    = 0;
    localparam int ST_ERR   = 1;
    localparam int ST_FRAME = 2;
    localparam logic [ST_W-1:0] MASK_RST = 3'h0;

    // -------------------------------------------------------------
    // monitor pin group and shift sequencer states
    // -------------------------------------------------------------
    typedef struct packed {
        logic data;
        logic sclk;
        logic load;
    } hrm_mon_t;

    localparam hrm_mon_t MON_LOW = 3'h0;

    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_DATA = 2'b01,
        SH_CLKH = 2'b10,
        SH_LOAD = 2'b11
    } hrm_shift_t;

endpackage

// file: design/hrm_ratediv.sv
// mid clock tick divider selected by the rate pins
module hrm_ratediv
    import hrm_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // synchronised rate code
    input  wire logic [1:0] rate_sel,
    // one-cycle mid clock enable
    output logic            tick
);

    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic [DIV_W-1:0] div_len;
    logic             wrap;

    // ratio per rate code, fastest at code 3
    assign div_len = (rate_sel == 2'h3) ? DIV_RATE3 :
                     (rate_sel == 2'h2) ? DIV_RATE2 :
                     (rate_sel == 2'h1) ? DIV_RATE1 : DIV_RATE0;
    assign wrap     = (cnt_reg >= div_len - 6'h01);
    assign cnt_next = wrap ? 6'h00 : cnt_reg + 6'h01;

    // divider counter and tick flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 6'h00;
            tick    <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick    <= wrap;
        end
    end

endmodule

// file: design/hrm_oneshot.sv
// retriggerable one-shot with active-low registered output
module hrm_oneshot
    import hrm_pkg::*;
#(
    parameter logic [CNT_W-1:0] LOAD = CNT_W'(LAMP_TICKS_DEF)
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // mid clock enable and trigger
    input  wire logic tick,
    input  wire logic trig,
    // indicator, low while running
    output logic      out_n
);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;

    // reload on trigger, count down on ticks
    assign cnt_next = trig ? LOAD :
                      (tick && cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;

    // reset loads the full time so the lamp test follows release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= LOAD;
            out_n   <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            out_n   <= (cnt_next == '0);
        end
    end

endmodule

// file: design/hrm_monitor.sv
// hub receive monitor: arbitration, indicator one-shots, serial port monitor
// -----------------------------------------------------------------------------
// Notes on behaviour
// - any accepted port reception drives rx_indicator_n low for a pulse time
// - rx_indicator_n low during reset and 500000 mid periods after release
// - rx one-shot retriggers; min low time 500000 mid periods
// - an error packet drives err_indicator_n low for a pulse time
// - err_indicator_n low during reset and 500000 mid periods after release
// - err one-shot retriggers; min low time 500000 mid periods
// - monitor data, shift clock and latch load all low during reset
// - record per port receptions over repeating 2^17 mid period intervals
// - shift the recorded status out during the following interval
// - simultaneous requests: only the lowest numbered port is accepted
// - mid clock divided from input clock by the two rate select pins
// -----------------------------------------------------------------------------
module hrm_monitor
    import hrm_pkg::*;
#(
    parameter int LAMP_TICKS = LAMP_TICKS_DEF,
    parameter int MON_TICKS  = MON_TICKS_DEF
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    // rate select pins
    input  wire logic              rate_select_0,
    input  wire logic              rate_select_1,
    // port receive requests from the packet logic
    input  wire logic [PORTS-1:0]  port_rx_req,
    input  wire logic              port_rx_err,
    output logic      [PORTS-1:0]  rx_grant,
    // indicator pins
    output logic                   rx_indicator_n,
    output logic                   err_indicator_n,
    // port monitor pins
    output logic                   monitor_serial_data,
    output logic                   monitor_shift_clock,
    output logic                   monitor_latch_load,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    // interrupt
    output logic                   irq
);

    // -------------------------------------------------------------------------
    // rate pins and mid clock enable
    // -------------------------------------------------------------------------
    logic [1:0] sel_meta_reg;
    logic [1:0] sel_sync_reg;
    logic       mid_tick;

    // two-flop synchroniser for the rate pins
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_meta_reg <= 2'h0;
            sel_sync_reg <= 2'h0;
        end else begin
            sel_meta_reg <= {rate_select_1, rate_select_0};
            sel_sync_reg <= sel_meta_reg;
        end
    end

    // mid clock as a one-cycle enable
    hrm_ratediv u_div (
        .clk      (ref_clk),
        .rst      (sys_rst),
        .rate_sel (sel_sync_reg),
        .tick     (mid_tick)
    );

    // -------------------------------------------------------------------------
    // receive arbitration
    // -------------------------------------------------------------------------
    logic [PORTS-1:0] grant_reg;
    logic [PORTS-1:0] grant_next;
    logic [PORTS-1:0] lowest_req;
    logic             idle;
    logic             held;
    logic             rx_event;
    logic             err_event;

    // lowest set request bit wins
    assign lowest_req = port_rx_req & (~port_rx_req + 8'h01);
    assign idle       = (grant_reg == 8'h00);
    assign held       = |(port_rx_req & grant_reg);
    assign rx_event   = idle && (port_rx_req != 8'h00);
    assign grant_next = rx_event ? lowest_req :
                        held ? grant_reg : 8'h00;
    // an error flagged while a reception is accepted
    assign err_event  = port_rx_err && !idle;
    assign rx_grant   = grant_reg;

    // grant held until the accepted port drops its request
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            grant_reg <= 8'h00;
        end else begin
            grant_reg <= grant_next;
        end
    end

    // -------------------------------------------------------------------------
    // indicator one-shots
    // -------------------------------------------------------------------------
    // rx lamp, loaded at reset for the lamp test
    hrm_oneshot #(
        .LOAD (CNT_W'(LAMP_TICKS))
    ) u_rx_led (
        .clk   (ref_clk),
        .rst   (sys_rst),
        .tick  (mid_tick),
        .trig  (rx_event),
        .out_n (rx_indicator_n)
    );

    // error lamp, same timing
    hrm_oneshot #(
        .LOAD (CNT_W'(LAMP_TICKS))
    ) u_err_led (
        .clk   (ref_clk),
        .rst   (sys_rst),
        .tick  (mid_tick),
        .trig  (err_event),
        .out_n (err_indicator_n)
    );

    // -------------------------------------------------------------------------
    // monitor interval and per-port record
    // -------------------------------------------------------------------------
    logic [MON_W-1:0] int_cnt_reg;
    logic             int_wrap;
    logic             frame_start;
    logic [PORTS-1:0] rec_reg;
    logic [PORTS-1:0] rec_hit;
    logic [PORTS-1:0] ports_reg;

    assign int_wrap    = (int_cnt_reg == MON_W'(MON_TICKS - 1));
    assign frame_start = mid_tick && int_wrap;
    // port accepted in this cycle
    assign rec_hit     = rx_event ? lowest_req : 8'h00;

    // interval counter on the mid clock
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            int_cnt_reg <= '0;
        end else if (mid_tick) begin
            int_cnt_reg <= int_wrap ? '0 : int_cnt_reg + 1'b1;
        end
    end

    // record, then snapshot at interval end; same-cycle hits kept
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rec_reg   <= 8'h00;
            ports_reg <= 8'h00;
        end else if (frame_start) begin
            rec_reg   <= 8'h00;
            ports_reg <= rec_reg | rec_hit;
        end else begin
            rec_reg   <= rec_reg | rec_hit;
        end
    end

    // -------------------------------------------------------------------------
    // serial shift sequencer
    // -------------------------------------------------------------------------
    hrm_shift_t       sh_state_reg;
    hrm_shift_t       sh_state_next;
    logic [PORTS-1:0] sh_reg;
    logic [PORTS-1:0] sh_next;
    logic [3:0]       bit_cnt_reg;
    logic [3:0]       bit_cnt_next;
    hrm_mon_t         mon_reg;
    hrm_mon_t         mon_next;
    logic             frame_done;

    // one step per mid tick: data, clock high, ..., latch load
    always_comb begin
        sh_state_next = sh_state_reg;
        sh_next       = sh_reg;
        bit_cnt_next  = bit_cnt_reg;
        mon_next      = mon_reg;
        if (frame_start) begin
            sh_state_next = SH_DATA;
            sh_next       = rec_reg | rec_hit;
            bit_cnt_next  = 4'h0;
        end else if (mid_tick) begin
            unique case (sh_state_reg)
                SH_IDLE: begin
                    mon_next = MON_LOW;
                end
                SH_DATA: begin
                    mon_next.data = sh_reg[PORTS-1];
                    mon_next.sclk = 1'b0;
                    sh_state_next = SH_CLKH;
                end
                SH_CLKH: begin
                    mon_next.sclk = 1'b1;
                    sh_next       = {sh_reg[PORTS-2:0], 1'b0};
                    bit_cnt_next  = bit_cnt_reg + 4'h1;
                    sh_state_next = (bit_cnt_reg == 4'h7) ? SH_LOAD : SH_DATA;
                end
                SH_LOAD: begin
                    mon_next.sclk = 1'b0;
                    mon_next.load = 1'b1;
                    sh_state_next = SH_IDLE;
                end
            endcase
        end
    end

    assign frame_done = mid_tick && !frame_start && (sh_state_reg == SH_LOAD);

    // sequencer flops; reset drives all monitor pins low
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sh_state_reg <= SH_IDLE;
            sh_reg       <= 8'h00;
            bit_cnt_reg  <= 4'h0;
            mon_reg      <= MON_LOW;
        end else begin
            sh_state_reg <= sh_state_next;
            sh_reg       <= sh_next;
            bit_cnt_reg  <= bit_cnt_next;
            mon_reg      <= mon_next;
        end
    end

    assign monitor_serial_data = mon_reg.data;
    assign monitor_shift_clock = mon_reg.sclk;
    assign monitor_latch_load  = mon_reg.load;

    // -------------------------------------------------------------------------
    // registers and interrupt
    // -------------------------------------------------------------------------
    logic [ST_W-1:0]   status_reg;
    logic [ST_W-1:0]   mask_reg;
    logic [ST_W-1:0]   st_set;
    logic [ST_W-1:0]   st_clr;
    logic              wr_status;
    logic              wr_mask;
    logic [DATA_W-1:0] rd_mux;

    assign wr_status = reg_wr && (reg_addr == REG_STATUS);
    assign wr_mask   = reg_wr && (reg_addr == REG_MASK);
    assign st_set    = {frame_done, err_event, rx_event};
    assign st_clr    = wr_status ? reg_wdata[ST_W-1:0] : 3'h0;

    // sticky status bits, set wins over write-one clear
    genvar gi;
    generate
        for (gi = 0; gi < ST_W; gi++) begin : g_status
            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    status_reg[gi] <= 1'b0;
                end else if (st_set[gi]) begin
                    status_reg[gi] <= 1'b1;
                end else if (st_clr[gi]) begin
                    status_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // read select; unmapped reads zero
    assign rd_mux = (reg_addr == REG_STATUS) ? {5'h00, status_reg} :
                    (reg_addr == REG_MASK)   ? {5'h00, mask_reg} :
                    (reg_addr == REG_PORTS)  ? ports_reg :
                    (reg_addr == REG_LIVE)   ?
                        {4'h0, monitor_latch_load, !err_indicator_n,
                         !rx_indicator_n, !idle} : 8'h00;

    // mask write and one-cycle read data
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mask_reg  <= MASK_RST;
            reg_rdata <= 8'h00;
        end else begin
            if (wr_mask) begin
                mask_reg <= reg_wdata[ST_W-1:0];
            end
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    assign irq = |(status_reg & mask_reg);

    // -------------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------------
    a_rx_led_on: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        rx_event |=> !rx_indicator_n)
        else $error("rx indicator not low after reception");

    a_err_led_on: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        err_event |=> !err_indicator_n)
        else $error("error indicator not low after error");

    a_lamp_test_hold: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        $fell(sys_rst) |-> (!rx_indicator_n && !err_indicator_n) [*8])
        else $error("lamp test not held after reset");

    a_mon_reset_low: assert property (
        @(posedge ref_clk)
        sys_rst |-> (mon_reg == MON_LOW))
        else $error("monitor pins not low in reset");

    a_grant_lowest: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        rx_event |=> (rx_grant == $past(lowest_req)))
        else $error("grant not given to lowest port");

    a_grant_onehot: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        $onehot0(rx_grant))
        else $error("more than one port granted");

    a_latch_after_eight: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        $rose(monitor_latch_load) |-> (bit_cnt_reg == 4'h8))
        else $error("latch load before eight bits");

    a_data_stable_clk: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        $rose(monitor_shift_clock) |-> $stable(monitor_serial_data))
        else $error("data moved at shift clock edge");

    a_tick_spacing: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        mid_tick |=> !mid_tick [*3])
        else $error("mid clock tick too frequent");

    a_frame_starts: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        frame_start |=> (sh_state_reg == SH_DATA && ports_reg == sh_reg))
        else $error("frame did not start shifting");

    c_rx_event: cover property (@(posedge ref_clk) disable iff (sys_rst)
        rx_event);
    c_multi_req: cover property (@(posedge ref_clk) disable iff (sys_rst)
        rx_event && !$onehot(port_rx_req));
    c_err_event: cover property (@(posedge ref_clk) disable iff (sys_rst)
        err_event);
    c_latch_load: cover property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(monitor_latch_load));

endmodule

// file: sim/hrm_lamp_model.sv
// external shift register, latch and port lamps fed by the monitor pins
module hrm_lamp_model (
    // monitor pins from the device
    input  wire logic       monitor_serial_data,
    input  wire logic       monitor_shift_clock,
    input  wire logic       monitor_latch_load,
    // one lamp per port, high when lit
    output logic      [7:0] lamps
);
    timeunit 1ns;
    timeprecision 100ps;

    // lamps stay unknown until the first latch pulse
    logic [7:0] shift_reg;

    // shift on each clock pulse, the first bit ends at the top
    always @(posedge monitor_shift_clock) begin
        shift_reg <= {shift_reg[6:0], monitor_serial_data};
    end

    // latch copies the whole byte to the lamps at once
    always @(posedge monitor_latch_load) begin
        lamps <= shift_reg;
    end
endmodule

// file: sim/hrm_monitor_tb_top.sv
// self-checking bench of the hub receive monitor
module hrm_monitor_tb_top
    import hrm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic              ref_clk;
    logic              sys_rst;
    logic [PORTS-1:0]  port_rx_req;
    logic              port_rx_err;
    logic [PORTS-1:0]  rx_grant;
    logic              rx_indicator_n;
    logic              err_indicator_n;
    logic              monitor_serial_data;
    logic              monitor_shift_clock;
    logic              monitor_latch_load;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic              irq;
    logic [7:0]        lamps;
    logic              rd_pend = 1'b0;
    logic [1:0]        rate_code;
    logic [7:0]        ind_pair;
    logic [7:0]        mon_pins;
    logic [7:0]        lfsr;
    logic [7:0]        pat;
    logic [7:0]        rd_q[$];
    logic [7:0]        frame_q[$];
    int                errors;
    int                n_checks;

    // short counts keep the run brief; rate code 3 ticks every 4 clocks
    hrm_monitor #(.LAMP_TICKS(40), .MON_TICKS(64)) hrm_monitor_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst),
        .rate_select_0(rate_code[0]), .rate_select_1(rate_code[1]),
        .port_rx_req(port_rx_req), .port_rx_err(port_rx_err),
        .rx_grant(rx_grant), .rx_indicator_n(rx_indicator_n),
        .err_indicator_n(err_indicator_n),
        .monitor_serial_data(monitor_serial_data),
        .monitor_shift_clock(monitor_shift_clock),
        .monitor_latch_load(monitor_latch_load),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq)
    );

    hrm_lamp_model hrm_lamp_model_inst (
        .monitor_serial_data(monitor_serial_data),
        .monitor_shift_clock(monitor_shift_clock),
        .monitor_latch_load(monitor_latch_load),
        .lamps(lamps)
    );

    // indicator pair and monitor pins packed for compares
    assign ind_pair = {6'h00, rx_indicator_n, err_indicator_n};
    assign mon_pins = {5'h00, monitor_serial_data, monitor_shift_clock,
                       monitor_latch_load};

    // 10 MHz clock
    initial ref_clk = 1'b0;
    always #50 ref_clk = ~ref_clk;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // lowest set bit wins the arbitration
    function automatic logic [7:0] lowest(input logic [7:0] r);
        return r & (~r + 8'h01);
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [ADDR_W-1:0] a,
                             input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // read strobe, the expected data waits in the queue
    task automatic reg_read(input logic [ADDR_W-1:0] a,
                            input logic [DATA_W-1:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        rd_q.push_back(exp);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask

    // one accepted reception, optionally flagged as an error packet
    task automatic grant_cycle(input logic [7:0] r, input logic err);
        @(posedge ref_clk);
        port_rx_req <= r;
        repeat (2) @(posedge ref_clk);
        check(rx_grant, lowest(r));
        check({7'h00, rx_indicator_n}, 8'h00);
        if (err) begin
            port_rx_err <= 1'b1;
        end
        @(posedge ref_clk);
        port_rx_err <= 1'b0;
        port_rx_req <= 8'h00;
        repeat (2) @(posedge ref_clk);
    endtask

    // wait for one latch pulse to start and end, bounded
    task automatic wait_load();
        int n;
        n = 0;
        while (monitor_latch_load !== 1'b1 && n < 600) begin
            @(posedge ref_clk);
            n++;
        end
        while (monitor_latch_load === 1'b1 && n < 600) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 600) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
        end
        @(posedge ref_clk);
    endtask

    // ---------------------------------------------------------------
    // output watchers
    // ---------------------------------------------------------------
    // read data stands in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (rd_pend && rd_q.size() > 0)
            check(reg_rdata, rd_q.pop_front());
        rd_pend <= reg_rd;
    end

    // lamps settle once the latch pulse ends
    always @(negedge monitor_latch_load) begin
        if (frame_q.size() > 0)
            check(lamps, frame_q.pop_front());
    end

    // hang guard, the whole run needs about 1500 cycles
    initial begin
        repeat (6000) @(posedge ref_clk);
        errors++;
        $display("Error at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
        report_and_stop();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        sys_rst     = 1'b1;
        rate_code   = 2'h3;
        port_rx_req = 8'h00;
        port_rx_err = 1'b0;
        reg_addr    = 4'h0;
        reg_wdata   = 8'h00;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        errors      = 0;
        n_checks    = 0;
        lfsr        = 8'h57;
        repeat (10) @(posedge ref_clk);
        check(mon_pins, 8'h00);
        check(ind_pair, 8'h00);
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (120) @(posedge ref_clk);
        check(ind_pair, 8'h00);
        repeat (80) @(posedge ref_clk);
        check(ind_pair, 8'h03);
        $display("test lamp after reset done");
        // each port wins once against random higher ports
        for (int i = 0; i < PORTS; i++) begin
            lfsr = lfsr_next(lfsr);
            pat  = (lfsr << i) | (8'h01 << i);
            grant_cycle(pat, i == 0);
            if (i == 0) begin
                check({7'h00, err_indicator_n}, 8'h00);
            end
        end
        // a late trigger stretches both pulses
        repeat (100) @(posedge ref_clk);
        grant_cycle(8'h80, 1'b1);
        repeat (100) @(posedge ref_clk);
        check(ind_pair, 8'h00);
        repeat (100) @(posedge ref_clk);
        check(ind_pair, 8'h03);
        $display("test arbitration and one-shots done");
        // record a random port set within one interval
        wait_load();
        wait_load();
        reg_write(REG_STATUS, 8'h07);
        reg_read(REG_STATUS, 8'h00);
        lfsr = lfsr_next(lfsr);
        pat  = lfsr;
        for (int i = 0; i < PORTS; i++) begin
            if (pat[i]) begin
                grant_cycle(8'h01 << i, 1'b0);
            end
        end
        frame_q.push_back(pat);
        reg_read(REG_STATUS, 8'h01);
        // live flags: rx lamp lit, err lamp dark, no grant, no load
        reg_read(REG_LIVE, 8'h02);
        reg_write(REG_MASK, 8'h01);
        @(posedge ref_clk);
        check({7'h00, irq}, 8'h01);
        reg_read(REG_MASK, 8'h01);
        reg_read(4'hf, 8'h00);
        reg_write(REG_STATUS, 8'h01);
        @(posedge ref_clk);
        check({7'h00, irq}, 8'h00);
        wait_load();
        reg_read(REG_PORTS, pat);
        reg_write(REG_MASK, 8'h04);
        @(posedge ref_clk);
        check({7'h00, irq}, 8'h01);
        $display("test port monitor frame done");
        // reset in mid run forces every pin low at once
        sys_rst   <= 1'b1;
        rate_code <= 2'h2;
        repeat (2) @(posedge ref_clk);
        check(mon_pins, 8'h00);
        check(ind_pair, 8'h00);
        check(rx_grant, 8'h00);
        check({7'h00, irq}, 8'h00);
        sys_rst <= 1'b0;
        // rate code 2 ticks every 8 clocks: lamp test lasts about 320
        repeat (300) @(posedge ref_clk);
        check(ind_pair, 8'h00);
        repeat (40) @(posedge ref_clk);
        check(ind_pair, 8'h03);
        $display("test reset in run done");
        report_and_stop();
    end
endmodule
